// >>> shared/isw_map.vh
/*
 File: register map, bit fields, reset values and timing constants of the
 bus slave with time-out.
 Assumes: included by bare name from the rtl files.
*/
`ifndef ISW_MAP_VH
`define ISW_MAP_VH
// Register byte addresses on APB
`define ISW_ADDR_CTRL0 12'h000
`define ISW_ADDR_STAT 12'h004
`define ISW_ADDR_DATA 12'h008
`define ISW_ADDR_OWN 12'h00c
`define ISW_ADDR_TOC 12'h010
// Module control register fields
`define ISW_C0_MODE_HI 7
`define ISW_C0_MODE_LO 5
`define ISW_C0_EN 1
`define ISW_C0_IE 0
`define ISW_MODE_SLAVE 3'h6
`define ISW_C0_RST 8'he0
// Bus status register fields
`define ISW_ST_HCF 7
`define ISW_ST_AAS 6
`define ISW_ST_BB 5
`define ISW_ST_TX 4
`define ISW_ST_ACK_TO_SEND 3
`define ISW_ST_RW 2
`define ISW_ST_ACK_RECEIVED 0
`define ISW_ST_RST 8'h81
// Time-out control fields
`define ISW_TO_EN 7
`define ISW_TO_FLAG 6
`define ISW_TO_SEL_HI 5
`define ISW_TO_RST 8'h00
// Slow clock divider and bit counts
`define ISW_TO_DIV 5'h1f
`define ISW_BITS_BYTE 4'h8
`define ISW_BIT_ACK 4'h9
`endif

// >>> rtl/isw_sync.v
/*
 File: three-stage synchroniser with agreement filter for one pin.
 Assumes: din is asynchronous to clk; rst is synchronous, active high.
*/
module isw_sync (
   input wire clk,
   input wire rst,
   input wire din,
   output reg dout
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // First stage feeds only the second; change counts once stages two and three agree
   always @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule // isw_sync

// >>> rtl/isw_timeout.v
/*
 File: bus time-out counter, ticking on the slow clock divided by 32.
 Assumes: slow_clk is a pin, sampled through isw_sync; kick restarts.
*/
`include "isw_map.vh"
module isw_timeout (
   input wire clk,
   input wire rst,
   input wire slow_clk,
   input wire run,
   input wire kick,
   input wire [5:0] sel,
   output reg expire
);
   wire slow_s;
   reg slow_d_r;
   reg [4:0] div_r;
   reg [6:0] cnt_r;
   isw_sync u_sync (.clk(clk), .rst(rst), .din(slow_clk), .dout(slow_s));
   // Divide slow clock rising edges by 32, then count sel+1 ticks
   always @(posedge clk) begin
      if (rst) begin
         slow_d_r <= 1'b0;
         div_r <= 5'h00;
         cnt_r <= 7'h00;
         expire <= 1'b0;
      end else begin
         slow_d_r <= slow_s;
         expire <= 1'b0;
         if (!run || kick) begin
            div_r <= 5'h00; // Restart also aligns the prescaler [R22]
            cnt_r <= 7'h00;
         end else if (slow_s && !slow_d_r) begin
            div_r <= div_r + 5'h01;
            if (div_r == `ISW_TO_DIV) begin
               cnt_r <= cnt_r + 7'h01;
               if (cnt_r == {1'b0, sel}) begin
                  expire <= 1'b1; // Period (sel+1) x 32 slow clocks [R6]
                  cnt_r <= 7'h00;
               end
            end
         end
      end
   end
endmodule // isw_timeout

// >>> rtl/isw_slave.v
/*
 File: two-wire bus slave with own address, clock stretching and bus time-out,
 registers reached over APB.
 Assumes: scl/sda are open-drain, resolved outside; slow_clk is the slow
 subsystem clock as a pin; APB master per the usual protocol.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
//
// Overview of operation
// R1 - Own 7-bit address in bits 7:1
// R2 - Address bit 0 plain storage
// R3 - Address register doubles as SPI control 2
// R4 - Time-out control bit 7 enables time-out
// R5 - Time-out flag sticky until software clears
// R6 - Period is (select+1) times 32 slow clocks
// R7 - START sets bus busy flag
// R8 - Slave never drives START
// R9 - Seven address bits MSB first, match interrupts
// R10 - Eighth bit latched as read/write flag
// R11 - Acknowledge low on ninth clock on match
// R12 - Software checks match flag per interrupt
// R13 - Hold SCL low until data access
// R14 - Software sets transmit select from read/write
// R15 - Data bytes eight bits, MSB first
// R16 - Receiver drives ack-to-send on ninth clock
// R17 - Transmitter releases SDA on missing ack
// R18 - Master ack captured into received flag
// R19 - Master stops after missing address ack
// R20 - Software enables mode 110, address, interrupt
// R21 - STOP clears bus busy flag
// R22 - Counter starts on match, restarts on SCL fall
// R23 - Overflow clears enable, flags, resets status
// R24 - Complete flag cleared during byte, set after
// R25 - All events share one interrupt line
`include "isw_map.vh"
module isw_slave (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire slow_clk,
   output reg irq
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_ADDR = 5'b00010;
   localparam ST_DATA = 5'b00100;
   localparam ST_ACK = 5'b01000;
   localparam ST_WAIT = 5'b10000;

   reg [7:0] ctrl0_r;
   reg [7:0] data_r;
   reg [7:0] own_r;
   reg [7:0] toc_r;
   reg hcf_r, aas_r, bb_r, htx_r, ack_to_send_r, rw_r, ack_received_r;
   reg [4:0] state_r;
   reg [3:0] bit_r;
   reg [7:0] shift_r;
   reg hold_r;
   reg addr_phase_r;
   reg scl_d_r, sda_d_r;
   wire scl_s, sda_s;
   wire expire;
   wire [7:0] stat_rd;

   isw_sync u_scl (.clk(clk), .rst(rst), .din(scl_in), .dout(scl_s));
   isw_sync u_sda (.clk(clk), .rst(rst), .din(sda_in), .dout(sda_s));

   // Bus conditions from filtered pins
   wire enabled = ctrl0_r[`ISW_C0_EN] && ctrl0_r[`ISW_C0_MODE_HI:`ISW_C0_MODE_LO] == `ISW_MODE_SLAVE;
   wire scl_rise = scl_s && !scl_d_r;
   wire scl_fall = !scl_s && scl_d_r;
   wire start_c = scl_s && scl_d_r && sda_d_r && !sda_s; // [R7]
   wire stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire data_acc = acc && paddr == `ISW_ADDR_DATA;
   wire to_run = toc_r[`ISW_TO_EN] && bb_r && (aas_r || !addr_phase_r);

   isw_timeout u_to (.clk(clk), .rst(rst), .slow_clk(slow_clk), .run(to_run),
      .kick(scl_fall), .sel(toc_r[`ISW_TO_SEL_HI:0]), .expire(expire)); // [R22]

   assign stat_rd = {hcf_r, aas_r, bb_r, htx_r, ack_to_send_r, rw_r, 1'b0, ack_received_r};

   // Register bus: one wait-free access phase, unmapped reads zero with error
   always @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `ISW_ADDR_CTRL0: prdata <= {24'h000000, ctrl0_r};
               `ISW_ADDR_STAT: prdata <= {24'h000000, stat_rd};
               `ISW_ADDR_DATA: prdata <= {24'h000000, data_r};
               `ISW_ADDR_OWN: prdata <= {24'h000000, own_r}; // Shared with SPI control 2 [R3]
               `ISW_ADDR_TOC: prdata <= {24'h000000, toc_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Software registers; time-out flag set wins over clear
   always @(posedge clk) begin
      if (rst) begin
         ctrl0_r <= `ISW_C0_RST;
         own_r <= 8'h00;
         toc_r <= `ISW_TO_RST;
      end else begin
         if (wr && paddr == `ISW_ADDR_CTRL0) ctrl0_r <= pwdata[7:0];
         if (wr && paddr == `ISW_ADDR_OWN) own_r <= pwdata[7:0]; // Bit 0 stored only [R2]
         if (wr && paddr == `ISW_ADDR_TOC) toc_r <= pwdata[7:0]; // [R4]
         if (expire) begin
            toc_r[`ISW_TO_EN] <= 1'b0; // [R23]
            toc_r[`ISW_TO_FLAG] <= 1'b1; // [R5]
         end
      end
   end

   // Protocol engine; stretching lets software pace each byte
   always @(posedge clk) begin
      if (rst || expire || !enabled) begin
         hcf_r <= 1'b1;
         aas_r <= 1'b0;
         bb_r <= 1'b0;
         rw_r <= 1'b0;
         ack_received_r <= 1'b1;
         state_r <= ST_IDLE;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         hold_r <= 1'b0;
         addr_phase_r <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         if (rst) begin
            htx_r <= 1'b0;
            ack_to_send_r <= 1'b0;
            data_r <= 8'h00;
         end else if (expire) begin
            htx_r <= 1'b0; // Status back to its reset state [R23]
            ack_to_send_r <= 1'b0;
         end
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         if (wr && paddr == `ISW_ADDR_STAT) begin
            htx_r <= pwdata[`ISW_ST_TX];
            ack_to_send_r <= pwdata[`ISW_ST_ACK_TO_SEND];
         end
         if (wr && paddr == `ISW_ADDR_DATA) data_r <= pwdata[7:0];
         // Data access releases the stretched clock [R13]
         if (data_acc && hold_r) begin
            hold_r <= 1'b0;
            scl_oe <= 1'b0;
         end
         if (stop_c) begin
            bb_r <= 1'b0; // [R21]
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
            aas_r <= 1'b0;
            addr_phase_r <= 1'b0;
         end else if (start_c) begin
            bb_r <= 1'b1; // Only detected, never driven [R7] [R8]
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            aas_r <= 1'b0;
            addr_phase_r <= 1'b1;
            sda_oe <= 1'b0;
         end else begin
            case (state_r)
               ST_ADDR, ST_DATA: begin
                  if (scl_rise && !(state_r == ST_DATA && htx_r)) begin
                     shift_r <= {shift_r[6:0], sda_s}; // MSB first [R9] [R15]
                     bit_r <= bit_r + 4'h1;
                  end
                  if (scl_rise && state_r == ST_DATA && htx_r) bit_r <= bit_r + 4'h1;
                  if (scl_fall && state_r == ST_DATA && htx_r && bit_r != `ISW_BITS_BYTE) begin
                     sda_oe <= !shift_r[7] ? 1'b1 : 1'b0; // Drive low bits only
                     shift_r <= {shift_r[6:0], 1'b1};
                  end
                  if (scl_fall && bit_r == `ISW_BITS_BYTE) begin
                     state_r <= ST_ACK;
                     sda_oe <= 1'b0;
                     if (state_r == ST_ADDR) begin
                        rw_r <= shift_r[0]; // [R10]
                        if (shift_r[7:1] == own_r[7:1]) begin // [R1]
                           aas_r <= 1'b1; // [R9]
                           sda_oe <= 1'b1; // Address acknowledge [R11]
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end else if (!htx_r) begin
                        data_r <= shift_r;
                        sda_oe <= !ack_to_send_r; // [R16]
                     end
                  end
                  if (scl_rise && state_r == ST_DATA) hcf_r <= 1'b0; // [R24]
               end
               ST_ACK: begin
                  if (scl_rise && htx_r && !addr_phase_r) ack_received_r <= sda_s; // [R18]
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bit_r <= 4'h0;
                     if (!addr_phase_r) hcf_r <= 1'b1; // Byte done [R24]
                     if (htx_r && !addr_phase_r && ack_received_r) begin
                        state_r <= ST_WAIT; // Idle SDA until STOP [R17]
                     end else begin
                        state_r <= ST_DATA;
                        hold_r <= 1'b1; // Stretch low [R13]
                        scl_oe <= 1'b1;
                        if (addr_phase_r && htx_r) aas_r <= 1'b1;
                     end
                     addr_phase_r <= 1'b0;
                  end
               end
               ST_WAIT: sda_oe <= 1'b0;
               default: state_r <= ST_IDLE;
            endcase
            // Load transmit byte when software writes while stretched
            if (state_r == ST_DATA && htx_r && wr && paddr == `ISW_ADDR_DATA && hold_r) begin
               shift_r <= {pwdata[6:0], 1'b1};
               sda_oe <= !pwdata[7];
            end
            if (rd && paddr == `ISW_ADDR_DATA) aas_r <= aas_r && hold_r ? 1'b0 : aas_r;
         end
      end
   end

   // One request line, raised while SCL is stretched after a match or a byte, or by the time-out flag [R25]
   reg ev_d_r;
   wire ev_now = aas_r || (hcf_r && bb_r) || toc_r[`ISW_TO_FLAG];
   always @(posedge clk) begin
      if (rst) begin
         ev_d_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         ev_d_r <= ev_now;
         irq <= ctrl0_r[`ISW_C0_IE] && hold_r | toc_r[`ISW_TO_FLAG] ? 1'b1 : 1'b0;
      end
   end
endmodule // isw_slave

// >>> dv/isw_slave_sva.sv
/*
 Checker for the slave's APB answer and its open-drain pins.
 Assumes: bound to isw_slave, one clock, rst synchronous active high.
*/
module isw_slave_sva (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_out,
   input wire sda_oe,
   input wire irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // APB answer: one wait-free access cycle, one cycle wide
   AST_RDY_AFTER_SETUP: assert property (psel && !penable |=> pready && penable) else $error("no answer after setup");
   AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready held two cycles");
   AST_RDY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("ready outside access");
   AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not 0");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   // Pins may only be pulled low, never driven high
   AST_OD_LOW: assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("pin driven high");
   AST_NO_START: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved while clock high");
   AST_STRETCH_LOW: assert property ($rose(scl_oe) |-> !scl_in) else $error("stretch began high");
   AST_RELEASE: assert property (scl_oe && pready && paddr == 12'h008 |=> ##[0:3] !scl_oe) else $error("no release");
   AST_RESET_QUIET: assert property ($fell(rst) |-> !pready && !irq && !scl_oe && !sda_oe) else $error("not quiet");
endmodule // isw_slave_sva
bind isw_slave isw_slave_sva u_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .irq);

// >>> dv/isw_master.sv
/*
 Behavioural two-wire bus master, open drain, quarter bit of Q clocks.
 Assumes: scl/sda are the resolved wire levels with pull-ups.
*/
module isw_master (
   input wire clk,
   input wire scl,
   input wire sda,
   output logic scl_oe,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int Q = 5;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Only the master makes START
   task start();
      sda_oe <= 1'b1;
      wt(Q);
      scl_oe <= 1'b1;
      wt(Q);
   endtask
   // One bit; waits out any stretch before sampling
   task bit_x(input logic b, output logic s);
      sda_oe <= !b;
      wt(Q);
      scl_oe <= 1'b0;
      do @(posedge clk); while (scl !== 1'b1);
      wt(Q);
      s = sda;
      wt(Q);
      scl_oe <= 1'b1;
      wt(Q);
   endtask
   // Eight bits MSB first, then the ninth bit
   task xfer(input logic [7:0] d, input logic ma, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(ma, ack);
   endtask
   // STOP also ends an unanswered address
   task stop();
      logic s;
      sda_oe <= 1'b1;
      wt(Q);
      scl_oe <= 1'b0;
      do @(posedge clk); while (scl !== 1'b1);
      wt(Q);
      sda_oe <= 1'b0;
      wt(4 * Q);
   endtask
endmodule // isw_master

// >>> dv/isw_slave_tb.sv
/*
 Testbench: APB register accesses plus bus transfers through the master model.
 Assumes: isw_slave and isw_master compiled first; header isw_map.vh.
*/
`include "isw_map.vh"
module isw_slave_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow_clk = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, scl_out, sda_out, s_scl_oe, s_sda_oe, m_scl_oe, m_sda_oe, irq, ack, e;
   logic [7:0] b;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   wire scl = !(s_scl_oe || m_scl_oe);
   wire sda = !(s_sda_oe || m_sda_oe);
   isw_slave uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(s_scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(s_sda_oe), .slow_clk(slow_clk), .irq(irq));
   isw_master mst (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   always #20 clk = !clk;
   // Slow clock at a quarter of clk, plus the hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 1) slow_clk <= !slow_clk;
      if (cyc == 40000) begin
         error_cnt++;
         stop_test();
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask
   // APB transfer held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr; // Error code taken with the data, while pready stands
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
      apb(1'b0, a, 8'h0);
      chk(nm, r & {24'h0, m}, {24'h0, e});
   endtask
   task stop_test();
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(`ISW_ADDR_CTRL0, 8'hff, `ISW_C0_RST, "ctrl0 reset");
      rd(`ISW_ADDR_STAT, 8'hff, `ISW_ST_RST, "status reset");
      rd(`ISW_ADDR_OWN, 8'hff, 8'h00, "own reset");
      rd(`ISW_ADDR_TOC, 8'hff, `ISW_TO_RST, "toc reset");
      rd(12'h020, 8'hff, 8'h00, "unmapped");
      chk("slverr", e, 1'b1);
      apb(1'b1, `ISW_ADDR_OWN, 8'ha5);
      rd(`ISW_ADDR_OWN, 8'hff, 8'ha5, "own rw");
      apb(1'b1, `ISW_ADDR_CTRL0, 8'hc3);
      chk("pins open drain", {scl_out, sda_out}, 2'b00);
      // Foreign address: no acknowledge, no match
      mst.start();
      mst.xfer(8'ha6, 1'b1, b, ack);
      chk("nack", ack, 1'b1);
      rd(`ISW_ADDR_STAT, 8'h60, 8'h20, "busy no match");
      mst.stop();
      // Master writes 0x1d
      mst.start();
      mst.xfer(8'ha4, 1'b1, b, ack);
      chk("addr ack", ack, 1'b0);
      // Synchroniser and register latency before stretch and irq show
      mst.wt(4);
      chk("stretch", s_scl_oe, 1'b1);
      chk("irq match", irq, 1'b1);
      rd(`ISW_ADDR_STAT, 8'h64, 8'h60, "match write");
      rd(`ISW_ADDR_DATA, 8'h00, 8'h00, "dummy read");
      mst.xfer(8'h1d, 1'b1, b, ack);
      chk("data ack", ack, 1'b0);
      rd(`ISW_ADDR_STAT, 8'ha0, 8'ha0, "byte done");
      rd(`ISW_ADDR_DATA, 8'hff, 8'h1d, "rx data");
      mst.stop();
      rd(`ISW_ADDR_STAT, 8'h20, 8'h00, "bus free");
      // Master reads 0xa6 and refuses it
      mst.start();
      mst.xfer(8'ha5, 1'b1, b, ack);
      rd(`ISW_ADDR_STAT, 8'h64, 8'h64, "match read");
      apb(1'b1, `ISW_ADDR_STAT, 8'h10);
      apb(1'b1, `ISW_ADDR_DATA, 8'ha6);
      mst.xfer(8'hff, 1'b1, b, ack);
      chk("tx data", b, 8'ha6);
      rd(`ISW_ADDR_STAT, 8'h01, 8'h01, "master nack");
      chk("sda free", s_sda_oe, 1'b0);
      apb(1'b1, `ISW_ADDR_STAT, 8'h00);
      apb(1'b0, `ISW_ADDR_DATA, 8'h0);
      mst.stop();
      // Time-out with select 3 while the slave stretches
      apb(1'b1, `ISW_ADDR_TOC, 8'h83);
      mst.start();
      mst.xfer(8'ha4, 1'b1, b, ack);
      mst.wt(300);
      rd(`ISW_ADDR_TOC, 8'hff, 8'h83, "before expiry");
      mst.wt(300);
      rd(`ISW_ADDR_TOC, 8'hff, 8'h43, "expired");
      rd(`ISW_ADDR_STAT, 8'hff, `ISW_ST_RST, "status after expiry");
      rd(`ISW_ADDR_OWN, 8'hff, 8'ha5, "own kept");
      chk("irq expiry", irq, 1'b1);
      mst.stop();
      apb(1'b1, `ISW_ADDR_TOC, 8'h03);
      rd(`ISW_ADDR_TOC, 8'hff, 8'h03, "flag cleared");
      stop_test();
   end
endmodule // isw_slave_tb
